// ---- logic/wl_controller.sv ----
`include "wl_defs.svh"
module wl_controller
  import wl_pkg::*;
#(
  parameter int CK_DIV = `WL_CK_DIV,
  parameter int DW = $clog2(2 * `WL_CK_DIV),
  parameter int TARGET_RANK = 0,
  parameter int HOLD = `WL_CMD_HOLD,
  parameter int T_MOD_CYC = `WL_CEIL(`WL_T_MOD_NS),
  parameter int T_MRD_CYC = `WL_CEIL(`WL_T_MRD_NS),
  parameter int T_DQSEN_CYC = `WL_CEIL(`WL_T_WLDQSEN_NS),
  parameter int T_WLMRD_CYC = `WL_CEIL(`WL_T_WLMRD_NS),
  parameter int T_DQSH_CYC = `WL_CEIL(`WL_T_DQSH_NS),
  parameter int T_DQSL_CYC = `WL_CEIL(`WL_T_DQSL_NS),
  parameter int T_WLO_CYC = `WL_FLOOR(`WL_T_WLO_NS),
  parameter int T_IS_CYC = `WL_CEIL(`WL_T_IS_NS)
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Link to device
  wl_if.ctl link,
  // User control
  input wire logic start_in,
  input wire logic [2:0] rtt_sel_in,
  // User status
  output logic busy_out,
  output logic done_out,
  output logic fail_out,
  output logic [1:0][DW-1:0] lane_delay_out
);
  localparam int P2 = 2 * CK_DIV;
  localparam int MRD = (T_WLMRD_CYC > T_DQSL_CYC) ? T_WLMRD_CYC : T_DQSL_CYC;

  if (CK_DIV < 2 || DW != $clog2(2 * CK_DIV)) begin
    $error("CK_DIV or DW not usable");
  end
  if (T_DQSH_CYC < 1 || T_DQSH_CYC >= P2 || HOLD < 1) begin
    $error("Strobe width or hold not usable");
  end

  function automatic mr_word_t mr1_word(input logic lv, input logic qo, input logic [2:0] rtt);
    mr1_word = `WL_MR1_RESET;
    mr1_word[`WL_A7] = lv;
    mr1_word[`WL_A12] = qo;
    mr1_word[`WL_A9] = rtt[2];
    mr1_word[`WL_A6] = rtt[1];
    mr1_word[`WL_A2] = rtt[0];
  endfunction

  // Outputs on while leveling restricted to three values
  function automatic logic [2:0] rtt_lvl(input logic [2:0] rtt);
    rtt_lvl = (rtt == `WL_RTT_RZQ2 || rtt == `WL_RTT_RZQ6) ? rtt : `WL_RTT_RZQ4;
  endfunction

  // ----------------------------------------
  // Link clock divider
  // ----------------------------------------
  logic [DW-1:0] ph_ff, nxt_ph;
  logic ck_ff, nxt_ck;

  always_comb begin
    nxt_ph = (ph_ff == DW'(P2 - 1)) ? '0 : ph_ff + DW'(1);
    nxt_ck = (nxt_ph < DW'(CK_DIV));
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ph_ff <= '0;
      ck_ff <= 1'b0;
    end else begin
      ph_ff <= nxt_ph;
      ck_ff <= nxt_ck;
    end
  end

  // ----------------------------------------
  // Leveling sequencer
  // ----------------------------------------
  logic [1:0] dq_s;
  wl_sync #(
    .W(2)
  ) u_dq_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .d_in({link.dq[8], link.dq[0]}),
    .q_out(dq_s),
    .qd_out()
  );

  ctl_state_t st_ff, nxt_st;
  logic [11:0] cnt_ff, nxt_cnt;
  logic odt_ff, nxt_odt, dqs_oe_ff, nxt_dqs_oe, cv_ff, nxt_cv, crank_ff, nxt_crank;
  logic busy_ff, nxt_busy, done_ff, nxt_done, fail_ff, nxt_fail, dterm_ff, nxt_dterm;
  logic [1:0] dqs_ff, nxt_dqs, lock_ff, nxt_lock, prev_ff, nxt_prev, hp_ff, nxt_hp;
  logic [2:0] rtt_ff, nxt_rtt;
  mr_word_t ca_ff, nxt_ca;
  logic [1:0][DW-1:0] dly_ff, nxt_dly;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff + 12'h001;
    {nxt_odt, nxt_dqs_oe, nxt_crank, nxt_dterm} = {odt_ff, dqs_oe_ff, crank_ff, dterm_ff};
    {nxt_busy, nxt_done, nxt_fail, nxt_rtt, nxt_ca} = {busy_ff, done_ff, fail_ff, rtt_ff, ca_ff};
    {nxt_dqs, nxt_lock, nxt_prev, nxt_hp, nxt_dly} = {dqs_ff, lock_ff, prev_ff, hp_ff, dly_ff};
    nxt_cv = 1'b0;
    unique case (st_ff)
      S_IDLE: begin
        nxt_cnt = 12'h000;
        if (start_in) begin
          nxt_st = S_OFFRANK;
          {nxt_busy, nxt_done, nxt_fail, nxt_lock, nxt_hp, nxt_dly} = {3'h4, 4'h0, {2 * DW{1'b0}}};
          nxt_rtt = rtt_sel_in;
          nxt_ca = mr1_word(1'b0, 1'b1, rtt_sel_in);
          nxt_crank = ~TARGET_RANK[0];
        end
      end
      S_OFFRANK: begin
        nxt_cv = (cnt_ff < 12'(HOLD));
        if (cnt_ff == 12'(HOLD + T_MRD_CYC)) begin
          nxt_st = S_ENTER;
          nxt_cnt = 12'h000;
          nxt_ca = mr1_word(1'b1, 1'b0, rtt_lvl(rtt_ff));
          nxt_crank = TARGET_RANK[0];
        end
      end
      S_ENTER, S_EXIT: begin
        nxt_cv = (cnt_ff < 12'(HOLD));
        if (cnt_ff == 12'(HOLD + 1)) begin
          nxt_st = (st_ff == S_ENTER) ? S_WMOD : S_WEXIT;
          nxt_cnt = 12'h000;
        end
      end
      S_WMOD: if (cnt_ff == 12'(T_MOD_CYC + `WL_SYNC_MARGIN)) begin
        nxt_st = S_DQSEN;
        nxt_cnt = 12'h000;
        {nxt_odt, nxt_dterm} = 2'h3;
      end
      S_DQSEN: if (cnt_ff == 12'(T_DQSEN_CYC)) begin
        nxt_st = S_WMRD;
        nxt_cnt = 12'h000;
        nxt_dqs_oe = 1'b1;
      end
      // Sweep starts at the clock fall so early samples read low and a 0-to-1 can appear
      S_WMRD: if (cnt_ff >= 12'(MRD) && ph_ff == DW'(CK_DIV - 1)) begin
        nxt_st = S_PULSE;
        nxt_cnt = 12'h000;
        for (int l = 0; l < 2; l++) nxt_dqs[l] = ~lock_ff[l] & (dly_ff[l] == '0);
      end
      S_PULSE: begin
        for (int l = 0; l < 2; l++) begin
          nxt_dqs[l] = ~lock_ff[l] & (nxt_cnt >= 12'(dly_ff[l])) & (nxt_cnt < 12'(dly_ff[l]) + 12'(T_DQSH_CYC));
        end
        if (cnt_ff == 12'(2 * P2 - 1)) begin
          nxt_st = S_WLO;
          nxt_cnt = 12'h000;
          nxt_dqs = 2'h0;
        end
      end
      S_WLO: if (cnt_ff == 12'(T_WLO_CYC + `WL_FB_LAT)) begin
        nxt_st = S_SAMPLE;
      end
      S_SAMPLE: begin
        for (int l = 0; l < 2; l++) begin
          if (!lock_ff[l]) begin
            if (hp_ff[l] && !prev_ff[l] && dq_s[l]) nxt_lock[l] = 1'b1;
            else if (dly_ff[l] == DW'(P2 - 1)) nxt_fail = 1'b1;
            else nxt_dly[l] = dly_ff[l] + DW'(1);
            nxt_prev[l] = dq_s[l];
            nxt_hp[l] = 1'b1;
          end
        end
        nxt_cnt = 12'h000;
        nxt_st = (nxt_lock == 2'h3 || nxt_fail) ? S_STOP : S_WMRD;
      end
      S_STOP: begin
        nxt_st = S_ODTOFF;
        nxt_cnt = 12'h000;
        nxt_dqs_oe = 1'b0;
        nxt_odt = 1'b0;
      end
      S_ODTOFF: if (cnt_ff == 12'(T_IS_CYC + T_MOD_CYC + `WL_SYNC_MARGIN)) begin
        nxt_st = S_EXIT;
        nxt_cnt = 12'h000;
        nxt_dterm = 1'b0;
        nxt_ca = mr1_word(1'b0, 1'b0, rtt_ff);
      end
      S_WEXIT: if (cnt_ff == 12'(T_MOD_CYC + `WL_SYNC_MARGIN)) begin
        nxt_st = S_DONE;
      end
      S_DONE: begin
        nxt_st = S_IDLE;
        {nxt_busy, nxt_done} = 2'h1;
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= S_IDLE;
      cnt_ff <= 12'h000;
      {odt_ff, dqs_oe_ff, cv_ff, crank_ff, busy_ff, done_ff, fail_ff, dterm_ff} <= 8'h00;
      {dqs_ff, lock_ff, prev_ff, hp_ff, rtt_ff} <= 11'h000;
      ca_ff <= `WL_MR1_RESET;
      dly_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      {odt_ff, dqs_oe_ff, cv_ff, crank_ff} <= {nxt_odt, nxt_dqs_oe, nxt_cv, nxt_crank};
      {busy_ff, done_ff, fail_ff, dterm_ff} <= {nxt_busy, nxt_done, nxt_fail, nxt_dterm};
      {dqs_ff, lock_ff, prev_ff, hp_ff, rtt_ff} <= {nxt_dqs, nxt_lock, nxt_prev, nxt_hp, nxt_rtt};
      ca_ff <= nxt_ca;
      dly_ff <= nxt_dly;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.ck = ck_ff;
  assign link.odt = odt_ff;
  assign link.dqs_t = dqs_ff;
  assign link.dqs_c = ~dqs_ff;
  assign link.dqs_oe = dqs_oe_ff;
  assign link.cmd_valid = cv_ff;
  assign link.cmd_rank = crank_ff;
  assign link.cmd_ba = `WL_MR1_BA;
  assign link.cmd_addr = ca_ff;
  assign link.dq_term = dterm_ff;
  assign busy_out = busy_ff;
  assign done_out = done_ff;
  assign fail_out = fail_ff;
  assign lane_delay_out = dly_ff;
endmodule

// ---- logic/wl_defs.svh ----
`ifndef WL_DEFS_SVH
`define WL_DEFS_SVH

// ----------------------------------------
// Clock and cycle conversion
// ----------------------------------------
`define WL_CLK_NS 8
`define WL_CEIL(ns) (((ns) + `WL_CLK_NS - 1) / `WL_CLK_NS)
`define WL_FLOOR(ns) ((((ns) / `WL_CLK_NS) < 1) ? 1 : ((ns) / `WL_CLK_NS))

// ----------------------------------------
// Mode register one
// ----------------------------------------
`define WL_MR1_BA 3'h1
`define WL_A7 7
`define WL_A12 12
`define WL_A9 9
`define WL_A6 6
`define WL_A2 2
`define WL_MR1_RESET 13'h0000
`define WL_LVL_MASK 13'h0080
`define WL_QOFF_MASK 13'h1000
`define WL_EXIT_MASK 13'h1266
`define WL_RTT_RZQ4 3'h1
`define WL_RTT_RZQ2 3'h2
`define WL_RTT_RZQ6 3'h3

// ----------------------------------------
// Timing in ns
// ----------------------------------------
`define WL_T_MOD_NS 15
`define WL_T_WLDQSEN_NS 25
`define WL_T_WLMRD_NS 40
`define WL_T_WLO_NS 9
`define WL_T_DQSH_NS 16
`define WL_T_DQSL_NS 16
`define WL_T_MRD_NS 32
`define WL_T_IS_NS 8

// ----------------------------------------
// Link handling counts
// ----------------------------------------
`define WL_CK_DIV 8
`define WL_CMD_HOLD 4
`define WL_SYNC_MARGIN 4
`define WL_FB_LAT 8
`endif

// ---- logic/wl_device.sv ----
`include "wl_defs.svh"
module wl_device
  import wl_pkg::*;
#(
  parameter int RANK_ID = 0,
  parameter int ALL_DQ = 0,
  parameter int T_MOD_CYC = `WL_CEIL(`WL_T_MOD_NS),
  parameter int T_WLO_CYC = `WL_FLOOR(`WL_T_WLO_NS)
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Link to controller
  wl_if.dev link,
  // Status
  output logic leveling_out,
  output logic qoff_out,
  output mr_word_t mr1_out,
  output logic strobe_term_out,
  output logic data_term_out,
  output logic cmd_error_out
);
  localparam int SW = 22;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (T_MOD_CYC < 1 || T_MOD_CYC > 4095) begin
    $error("T_MOD_CYC out of range");
  end
  if (T_WLO_CYC < 1 || T_WLO_CYC > 4095) begin
    $error("T_WLO_CYC out of range");
  end
  if (ALL_DQ != 0 && ALL_DQ != 1) begin
    $error("ALL_DQ must be 0 or 1");
  end
  if (RANK_ID != 0 && RANK_ID != 1) begin
    $error("RANK_ID must be 0 or 1");
  end

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  logic [SW-1:0] synd;

  assign raw = {
    link.cmd_valid,
    link.cmd_rank,
    link.cmd_ba,
    link.cmd_addr,
    link.ck,
    link.odt,
    link.dqs_t
  };

  // Command word is held stable around the strobe, so a bitwise
  // two-stage crossing is safe here
  wl_sync #(
    .W(SW)
  ) u_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .d_in(raw),
    .q_out(syn),
    .qd_out(synd)
  );

  logic cv;
  logic cvd;
  logic crank;
  logic [2:0] cba;
  mr_word_t caddr;
  logic ck_s;
  logic odt_s;
  logic [1:0] dqs_s;
  logic [1:0] dqs_d;

  assign cv = syn[21];
  assign cvd = synd[21];
  assign crank = syn[20];
  assign cba = syn[19:17];
  assign caddr = syn[16:4];
  assign ck_s = syn[3];
  assign odt_s = syn[2];
  assign dqs_s = syn[1:0];
  assign dqs_d = synd[1:0];

  // ----------------------------------------
  // Mode register one
  // ----------------------------------------
  mr_word_t mr1_ff, nxt_mr1;
  logic [11:0] mod_cnt_ff, nxt_mod_cnt;
  logic err_ff, nxt_err;
  logic take;
  logic lvl;
  logic odt_ok;
  logic rtt_nz;

  assign take = cv & ~cvd & (crank == RANK_ID[0]);
  assign lvl = mr1_ff[`WL_A7];
  assign odt_ok = lvl & (mod_cnt_ff == 12'h000);
  assign rtt_nz = mr1_ff[`WL_A9] | mr1_ff[`WL_A6] | mr1_ff[`WL_A2];

  always_comb begin
    nxt_mr1 = mr1_ff;
    nxt_mod_cnt = mod_cnt_ff;
    nxt_err = err_ff;
    if (mod_cnt_ff != 12'h000) begin
      nxt_mod_cnt = mod_cnt_ff - 12'h001;
    end
    if (take && cba == `WL_MR1_BA) begin
      if (!lvl) begin
        nxt_mr1 = caddr;
        if (caddr[`WL_A7]) begin
          nxt_mod_cnt = 12'(T_MOD_CYC);
        end
      end else if (!caddr[`WL_A7]) begin
        nxt_mr1 = (mr1_ff & ~(`WL_EXIT_MASK | `WL_LVL_MASK)) | (caddr & `WL_EXIT_MASK);
      end else begin
        // Other bits frozen while leveling
        nxt_mr1 = (mr1_ff & ~`WL_QOFF_MASK) | (caddr & `WL_QOFF_MASK);
      end
    end else if (take && lvl) begin
      nxt_err = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mr1_ff <= `WL_MR1_RESET;
      mod_cnt_ff <= 12'h000;
      err_ff <= 1'b0;
    end else begin
      mr1_ff <= nxt_mr1;
      mod_cnt_ff <= nxt_mod_cnt;
      err_ff <= nxt_err;
    end
  end

  // ----------------------------------------
  // Per-lane clock sampling
  // ----------------------------------------
  logic [1:0] smp_ff, nxt_smp;
  logic [1:0] fb_ff, nxt_fb;
  logic [1:0] seen_ff, nxt_seen;
  logic [1:0][11:0] wlo_ff, nxt_wlo;

  always_comb begin
    nxt_smp = smp_ff;
    nxt_fb = fb_ff;
    nxt_seen = seen_ff;
    nxt_wlo = wlo_ff;
    for (int l = 0; l < 2; l++) begin
      if (wlo_ff[l] != 12'h000) begin
        nxt_wlo[l] = wlo_ff[l] - 12'h001;
        if (wlo_ff[l] == 12'h001) begin
          nxt_fb[l] = smp_ff[l];
          nxt_seen[l] = 1'b1;
        end
      end
      if (lvl && dqs_s[l] && !dqs_d[l]) begin
        // Clock and strobe share sync latency, so their relation holds
        nxt_smp[l] = ck_s;
        nxt_wlo[l] = 12'(T_WLO_CYC);
      end
    end
    if (!lvl) begin
      nxt_seen = 2'h0;
      nxt_fb = 2'h0;
      nxt_wlo = '0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smp_ff <= 2'h0;
      fb_ff <= 2'h0;
      seen_ff <= 2'h0;
      wlo_ff <= '0;
    end else begin
      smp_ff <= nxt_smp;
      fb_ff <= nxt_fb;
      seen_ff <= nxt_seen;
      wlo_ff <= nxt_wlo;
    end
  end

  // ----------------------------------------
  // Data pins and termination
  // ----------------------------------------
  function automatic logic [7:0] lane_bits(
    input logic fb,
    input logic seen,
    input logic junk,
    input int all
  );
    lane_bits = {8{junk}};
    if (seen) begin
      lane_bits = (all != 0) ? {8{fb}} : {7'h00, fb};
    end
  endfunction

  logic [15:0] dq_ff, nxt_dq;
  logic [15:0] dq_oe_ff, nxt_dq_oe;
  logic sterm_ff, nxt_sterm;
  logic dterm_ff, nxt_dterm;

  always_comb begin
    nxt_dq_oe = (lvl && !mr1_ff[`WL_A12]) ? 16'hFFFF : 16'h0000;
    for (int l = 0; l < 2; l++) begin
      // Whole lane from one flop stage, so bit skew is nil
      // Before the first sample the lane carries no meaning
      nxt_dq[l*8 +: 8] = lane_bits(fb_ff[l], seen_ff[l], ck_s, ALL_DQ);
    end
    if (lvl) begin
      nxt_sterm = odt_ok & odt_s;
      nxt_dterm = 1'b0;
    end else begin
      nxt_sterm = odt_s & rtt_nz;
      nxt_dterm = odt_s & rtt_nz;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dq_ff <= 16'h0000;
      dq_oe_ff <= 16'h0000;
      sterm_ff <= 1'b0;
      dterm_ff <= 1'b0;
    end else begin
      dq_ff <= nxt_dq;
      dq_oe_ff <= nxt_dq_oe;
      sterm_ff <= nxt_sterm;
      dterm_ff <= nxt_dterm;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.dev_dq = dq_ff;
  assign link.dev_dq_oe = dq_oe_ff;
  assign leveling_out = mr1_ff[`WL_A7];
  assign qoff_out = mr1_ff[`WL_A12];
  assign mr1_out = mr1_ff;
  assign strobe_term_out = sterm_ff;
  assign data_term_out = dterm_ff;
  assign cmd_error_out = err_ff;
endmodule

// ---- logic/wl_if.sv ----
interface wl_if;
  logic ck;
  logic odt;
  logic [1:0] dqs_t;
  logic [1:0] dqs_c;
  logic dqs_oe;
  logic cmd_valid;
  logic cmd_rank;
  logic [2:0] cmd_ba;
  logic [12:0] cmd_addr;
  logic dq_term;
  logic [15:0] dev_dq;
  logic [15:0] dev_dq_oe;
  logic [15:0] dq;
  // Undriven pins read low through the controller termination
  assign dq = dev_dq & dev_dq_oe;
  modport dev(
    input ck, odt, dqs_t, dqs_c, dqs_oe,
    input cmd_valid, cmd_rank, cmd_ba, cmd_addr,
    output dev_dq, dev_dq_oe
  );
  modport ctl(
    output ck, odt, dqs_t, dqs_c, dqs_oe,
    output cmd_valid, cmd_rank, cmd_ba, cmd_addr,
    output dq_term,
    input dq
  );
endinterface

// ---- logic/wl_pkg.sv ----
package wl_pkg;
  typedef logic [12:0] mr_word_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_OFFRANK = 4'h1,
    S_ENTER = 4'h2,
    S_WMOD = 4'h3,
    S_DQSEN = 4'h4,
    S_WMRD = 4'h5,
    S_PULSE = 4'h6,
    S_WLO = 4'h7,
    S_SAMPLE = 4'h8,
    S_STOP = 4'h9,
    S_ODTOFF = 4'hA,
    S_EXIT = 4'hB,
    S_WEXIT = 4'hC,
    S_DONE = 4'hD
  } ctl_state_t;
endpackage

// ---- logic/wl_sync.sv ----
module wl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out,
  output logic [W-1:0] qd_out
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff;
  logic [W-1:0] nxt_s1, nxt_s2, nxt_s3;

  if (W < 1) begin
    $error("W must be at least 1");
  end

  always_comb begin
    nxt_s1 = d_in;
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
    end
  end

  // Third stage only feeds edge detection downstream
  assign q_out = s2_ff;
  assign qd_out = s3_ff;
endmodule

// ---- sim/ddr_write_leveling_tb_top.sv ----
module ddr_write_leveling_tb_top import wl_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in, rst_n_in, start_in, ck_run;
  logic [2:0] rtt_sel_in;
  logic busy_out, done_out, fail_out, leveling_out, qoff_out, strobe_term_out, data_term_out, cmd_error_out;
  logic [1:0][3:0] lane_delay_out;
  mr_word_t mr1_out, b_mr1, w;
  logic b_lvl, b_qoff, b_sterm, b_dterm, b_err, ckv;
  int bad_count, samples_checked, n, i, exp_rtt, seed, err_m;
  logic [12:0] m;
  wl_if u_link();
  wl_if u_bad();
  assign u_bad.dqs_c = ~u_bad.dqs_t;
  wl_controller i_wl_controller (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(u_link.ctl),
    .start_in(start_in), .rtt_sel_in(rtt_sel_in), .busy_out(busy_out), .done_out(done_out),
    .fail_out(fail_out), .lane_delay_out(lane_delay_out));
  wl_device i_wl_device (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(u_link.dev),
    .leveling_out(leveling_out), .qoff_out(qoff_out), .mr1_out(mr1_out), .strobe_term_out(strobe_term_out),
    .data_term_out(data_term_out), .cmd_error_out(cmd_error_out));
  // Second device faces the bench, which breaks the command rules on purpose
  wl_device i_wl_device_b (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(u_bad.dev),
    .leveling_out(b_lvl), .qoff_out(b_qoff), .mr1_out(b_mr1), .strobe_term_out(b_sterm),
    .data_term_out(b_dterm), .cmd_error_out(b_err));
  wl_link_assertions i_wl_link_assertions (.clock_in(clock_in), .rst_n_in(rst_n_in), .ck(u_link.ck),
    .odt(u_link.odt), .dqs_t(u_link.dqs_t), .dqs_c(u_link.dqs_c), .dqs_oe(u_link.dqs_oe),
    .cmd_valid(u_link.cmd_valid), .cmd_rank(u_link.cmd_rank), .cmd_ba(u_link.cmd_ba),
    .cmd_addr(u_link.cmd_addr), .dq_term(u_link.dq_term), .dev_dq_oe(u_link.dev_dq_oe), .dq(u_link.dq));
  // ----------------------------------------
  // Clocks
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // Offset keeps link edges off the system clock edges
  initial begin
    u_bad.ck = 1'b0;
    #3.3;
    forever #62.5 if (ck_run) u_bad.ck = ~u_bad.ck;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check_bit(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_word(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic give_up(int cnt, int lim);
    if (cnt >= lim) begin
      bad_count++;
      $display("wrong value wait expected event seen timeout");
      tally_and_finish();
    end
  endtask
  // Look after the edge so registered outputs have settled
  task automatic tick();
    @(posedge clock_in);
    #1;
  endtask
  // Mode register model: leveling restricts which bits a command may touch
  task automatic bad_cmd(logic [2:0] ba, logic [12:0] word);
    @(posedge clock_in);
    u_bad.cmd_ba <= ba;
    u_bad.cmd_addr <= word;
    @(posedge clock_in);
    u_bad.cmd_valid <= 1'b1;
    repeat (4) @(posedge clock_in);
    u_bad.cmd_valid <= 1'b0;
    if (!m[7]) m = word;
    else if (ba != 3'h1) err_m = 1;
    else if (word[7]) m[12] = word[12];
    else m = (m & 13'h0d19) | (word & 13'h1266);
    repeat (3) @(posedge clock_in);
    #1;
    check_word("mode register one", m, b_mr1);
    check_bit("output off", m[12], b_qoff);
  endtask
  task automatic bad_pulse(int lane);
    @(posedge clock_in);
    u_bad.dqs_t[lane] <= 1'b1;
    @(posedge clock_in);
    ckv = u_bad.ck;
    @(posedge clock_in);
    u_bad.dqs_t[lane] <= 1'b0;
    repeat (8) @(posedge clock_in);
    #1;
    check_word("feedback lane", {7'h00, ckv}, u_bad.dq[lane*8 +: 8]);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    bad_count = 0;
    samples_checked = 0;
    seed = 39;
    m = 13'h0000;
    err_m = 0;
    rst_n_in = 1'b0;
    start_in = 1'b0;
    rtt_sel_in = 3'h0;
    ck_run = 1'b0;
    u_bad.odt = 1'b0;
    u_bad.dqs_t = 2'b00;
    u_bad.dqs_oe = 1'b0;
    u_bad.cmd_valid = 1'b0;
    u_bad.cmd_rank = 1'b0;
    u_bad.cmd_ba = 3'h1;
    u_bad.cmd_addr = 13'h0000;
    u_bad.dq_term = 1'b1;
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    ck_run <= 1'b1;
    bad_cmd(3'h1, 13'h0084);
    repeat (4) @(posedge clock_in);
    u_bad.odt <= 1'b1;
    repeat (6) @(posedge clock_in);
    #1;
    check_bit("strobe term", 1'b1, b_sterm);
    check_bit("data term", 1'b0, b_dterm);
    u_bad.dqs_oe <= 1'b1;
    for (i = 0; i < 6; i++) begin
      repeat ($random(seed) & 7) @(posedge clock_in);
      bad_pulse(i & 1);
    end
    check_word("data enables", 16'hffff, u_bad.dev_dq_oe);
    bad_cmd(3'h1, 13'h1fff);
    check_word("data enables", 16'h0000, u_bad.dev_dq_oe);
    bad_cmd(3'h1, 13'h0080);
    bad_cmd(3'h0, 13'h0000);
    check_bit("command error", err_m[0], b_err);
    u_bad.dqs_oe <= 1'b0;
    u_bad.odt <= 1'b0;
    repeat (6) @(posedge clock_in);
    #1;
    check_bit("strobe term", 1'b0, b_sterm);
    w = 13'($random(seed));
    w[7] = 1'b0;
    bad_cmd(3'h1, w);
    check_bit("leveling", 1'b0, b_lvl);
    ck_run <= 1'b0;
    $display("device rule test done");
    for (i = 0; i < 10; i++) begin
      exp_rtt = (i < 8) ? i : ($random(seed) & 7);
      @(posedge clock_in);
      rtt_sel_in <= exp_rtt[2:0];
      start_in <= 1'b1;
      @(posedge clock_in);
      start_in <= 1'b0;
      for (n = 0; n < 2000 && leveling_out !== 1'b1; n++) tick();
      give_up(n, 2000);
      #1;
      check_word("entry rtt", (exp_rtt == 2 || exp_rtt == 3) ? exp_rtt : 1,
        {mr1_out[9], mr1_out[6], mr1_out[2]});
      check_bit("output off", 1'b0, qoff_out);
      check_bit("busy", 1'b1, busy_out);
      for (n = 0; n < 200 && strobe_term_out !== 1'b1; n++) tick();
      give_up(n, 200);
      check_bit("data term", 1'b0, data_term_out);
      for (n = 0; n < 8000 && done_out !== 1'b1; n++) tick();
      give_up(n, 8000);
      #1;
      check_bit("fail", 1'b0, fail_out);
      check_bit("lower lock", 1'b1, lane_delay_out[0] != 4'h0);
      check_bit("upper lock", 1'b1, lane_delay_out[1] != 4'h0);
      check_word("exit rtt", exp_rtt, {mr1_out[9], mr1_out[6], mr1_out[2]});
      check_bit("leveling", 1'b0, leveling_out);
      check_bit("busy", 1'b0, busy_out);
      check_bit("command error", 1'b0, cmd_error_out);
      $display("leveling run %0d done", i);
    end
    tally_and_finish();
  end
endmodule

// ---- sim/wl_link_assertions.sv ----
module wl_link_assertions (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Link signals
  input wire logic ck,
  input wire logic odt,
  input wire logic [1:0] dqs_t,
  input wire logic [1:0] dqs_c,
  input wire logic dqs_oe,
  input wire logic cmd_valid,
  input wire logic cmd_rank,
  input wire logic [2:0] cmd_ba,
  input wire logic [12:0] cmd_addr,
  input wire logic dq_term,
  input wire logic [15:0] dev_dq_oe,
  input wire logic [15:0] dq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------
  // Link checks
  // ----------------------------------------
  chk_strobe_pair_compl: assert property (dqs_c == ~dqs_t)
    else $error("strobe pair not complementary");
  chk_cmd_bank_one: assert property (cmd_valid |-> cmd_ba == 3'h1)
    else $error("command outside mode register one");
  chk_cmd_word_held: assert property ($rose(cmd_valid) |-> (cmd_valid && $stable(cmd_addr)) [*4])
    else $error("command word not held");
  chk_odt_before_strobe: assert property ($rose(dqs_oe) |-> odt && dq_term)
    else $error("strobes driven without termination");
  chk_strobe_low_wait: assert property ($rose(dqs_oe) |-> (dqs_t == 2'b00) [*4])
    else $error("strobe not held low after enable");
  chk_pulse_high_width: assert property ($rose(dqs_t[0]) |-> (dqs_oe && dqs_t[0]) [*2])
    else $error("strobe high pulse too short");
  chk_pulse_low_width: assert property ($fell(dqs_t[1]) |-> !dqs_t[1] [*2])
    else $error("strobe low pulse too short");
  chk_exit_released: assert property ($rose(cmd_valid) && !cmd_addr[7] |-> !odt && !dqs_oe)
    else $error("exit command with link still active");
  // Six edges cover the two sync stages plus the sample, feedback and output flops
  chk_feedback_lower: assert property ($rose(dqs_t[0]) |-> ##6 (dq[0] == $past(ck, 6)))
    else $error("lower lane feedback wrong");
  chk_feedback_upper: assert property ($rose(dqs_t[1]) |-> ##6 (dq[8] == $past(ck, 6)))
    else $error("upper lane feedback wrong");
  chk_others_low: assert property ($rose(dqs_t[0]) |-> ##6 (dq[7:1] == 7'h00) [*4])
    else $error("spare data bits not low");
  chk_outputs_on: assert property (
    $rose(cmd_valid) && !cmd_rank && cmd_addr[7] && !cmd_addr[12] |-> ##[3:6] (dev_dq_oe == 16'hffff))
    else $error("data outputs not enabled");
endmodule
